// File: src/dscp_blank_timer.sv
`timescale 1ns/1ps
module dscp_blank_timer
  import dscp_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // control
  input wire logic over_i,
  input wire logic [3:0] code_i,
  // result
  output logic expired_o
);
  import dscp_pkg::*;

  logic [DSCP_CNT_W-1:0] cnt_r;
  logic [DSCP_CNT_W-1:0] cnt_nxt;
  logic [DSCP_CNT_W-1:0] limit;

  // product of code and step always fits: 15 * 15250 < 2^18
  assign limit = DSCP_CNT_W'(32'(code_i) * DSCP_DLY_STEP_CYC);

  always_comb
  begin
    cnt_nxt = cnt_r;
    if (!over_i)
    begin
      cnt_nxt = '0;
    end
    else if (cnt_r <= limit)
    begin
      cnt_nxt = cnt_r + DSCP_CNT_W'(1);
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cnt_r <= '0;
    end
    else
    begin
      cnt_r <= cnt_nxt;
    end
  end

  // longer than the delay: one cycle past the limit
  assign expired_o = over_i && (cnt_r > limit);

endmodule : dscp_blank_timer

// File: src/dscp_pkg.sv
package dscp_pkg;

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [7:0] DSCP_SCD_OFFSET = 8'h08;
  localparam logic [7:0] DSCP_SCD_RESET = 8'h00;
  localparam int DSCP_THR_LSB = 0;
  localparam int DSCP_DLY_LSB = 4;
  localparam int DSCP_DISCHARGE_SHORT_SENSE_DISABLE_BIT = 4;

  // ---------------------------------------------------------------
  // threshold in millivolts: base plus step per code
  // ---------------------------------------------------------------
  localparam int DSCP_THR_BASE_MV = 100;
  localparam int DSCP_THR_STEP_MV = 25;
  localparam int DSCP_THR_MAX_MV = 475;
  localparam int DSCP_MV_W = 10;

  // ---------------------------------------------------------------
  // blanking delay: code times one step
  // ---------------------------------------------------------------
  localparam int DSCP_CLK_MHZ = 250;
  localparam int DSCP_DLY_STEP_US = 61;
  localparam int DSCP_DLY_MAX_US = 915;
  localparam int DSCP_DLY_STEP_CYC = DSCP_DLY_STEP_US * DSCP_CLK_MHZ;
  localparam int DSCP_CNT_W = 18;

  typedef enum logic [1:0] {
    DSCP_CFG_ZERO_VOLT_CHARGE_DRIVE_FET,
    DSCP_CFG_COMMON_FET,
    DSCP_CFG_PRECHG_FET
  } dscp_cfg_t;

  // gate drive bundle, 1 = fet on
  typedef struct packed {
    logic charge_gate_drive;
    logic discharge_gate_drive;
    logic zero_volt_charge_drive;
  } dscp_drv_t;

endpackage : dscp_pkg

// File: src/dscp_top.sv
`timescale 1ns/1ps
module dscp_top
  import dscp_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // register port
  input wire logic reg_wr_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  // host control levels
  input wire logic discharge_short_sense_disable_i,
  input wire dscp_pkg::dscp_drv_t host_drv_i,
  input wire dscp_pkg::dscp_cfg_t fet_cfg_i,
  // analog comparator levels, asynchronous
  input wire logic [DSCP_MV_W-1:0] sense_mv_i,
  input wire logic precharge_mode_select_i,
  input wire logic supply_good_i,
  // outputs
  output dscp_pkg::dscp_drv_t drv_o,
  output logic regulator_on_o,
  output logic short_tripped_o
);
  import dscp_pkg::*;

  // -------------------------------------------------------------
  // input synchronisers
  // -------------------------------------------------------------
  // the sense value is a settled converter word; syncing bitwise is
  // tolerated because a torn sample only shifts one compare cycle
  logic [DSCP_MV_W+1:0] sync1_r;
  logic [DSCP_MV_W+1:0] sync2_r;
  logic [DSCP_MV_W-1:0] sense_s;
  logic pms_s;
  logic pgood_s;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sync1_r <= '0;
      sync2_r <= '0;
    end
    else
    begin
      sync1_r <= {supply_good_i, precharge_mode_select_i, sense_mv_i};
      sync2_r <= sync1_r;
    end
  end

  assign sense_s = sync2_r[DSCP_MV_W-1:0];
  assign pms_s = sync2_r[DSCP_MV_W];
  assign pgood_s = sync2_r[DSCP_MV_W+1];

  // -------------------------------------------------------------
  // configuration register
  // -------------------------------------------------------------
  logic [7:0] cfg_r;
  logic [7:0] cfg_nxt;
  logic [3:0] thr_code;
  logic [3:0] dly_code;

  always_comb
  begin
    cfg_nxt = cfg_r;
    if (reg_wr_i && reg_addr_i == DSCP_SCD_OFFSET)
    begin
      cfg_nxt = reg_wdata_i;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cfg_r <= DSCP_SCD_RESET;
    end
    else
    begin
      cfg_r <= cfg_nxt;
    end
  end

  assign thr_code = cfg_r[DSCP_THR_LSB+:4];
  assign dly_code = cfg_r[DSCP_DLY_LSB+:4];
  // unmapped addresses read zero
  assign reg_rdata_o = (reg_addr_i == DSCP_SCD_OFFSET) ? cfg_r : 8'h00;

  // -------------------------------------------------------------
  // threshold compare and blanking
  // -------------------------------------------------------------
  logic [DSCP_MV_W-1:0] thr_mv;
  logic over;
  logic expired;

  assign thr_mv = DSCP_MV_W'(DSCP_THR_BASE_MV + 32'(thr_code) * DSCP_THR_STEP_MV);
  assign over = !discharge_short_sense_disable_i && (sense_s > thr_mv);

  dscp_blank_timer u_timer (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .over_i(over),
    .code_i(dly_code),
    .expired_o(expired)
  );

  // -------------------------------------------------------------
  // trip latch and power-up sequence
  // -------------------------------------------------------------
  // the trip holds until the host drives all off with expired low, or supply good drops, so a
  // fault cannot be re-armed by a stale host level
  typedef enum logic [1:0] {
    DSCP_ST_DOWN,
    DSCP_ST_RUN,
    DSCP_ST_TRIP
  } dscp_state_t;

  dscp_state_t st_r;
  dscp_state_t st_nxt;
  dscp_drv_t drv_nxt;
  logic reg_on_nxt;

  always_comb
  begin
    st_nxt = st_r;
    case (st_r)
      DSCP_ST_DOWN:
      begin
        if (pgood_s)
        begin
          st_nxt = DSCP_ST_RUN;
        end
      end
      DSCP_ST_RUN:
      begin
        if (expired)
        begin
          st_nxt = DSCP_ST_TRIP;
        end
      end
      DSCP_ST_TRIP:
      begin
        if (host_drv_i == '0 && !expired)
        begin
          st_nxt = DSCP_ST_RUN;
        end
      end
      default:
      begin
        st_nxt = DSCP_ST_DOWN;
      end
    endcase
    if (!pgood_s)
    begin
      st_nxt = DSCP_ST_DOWN;
    end
  end

  always_comb
  begin
    drv_nxt = '0;
    reg_on_nxt = 1'b0;
    case (st_nxt)
      DSCP_ST_DOWN:
      begin
        if (fet_cfg_i == DSCP_CFG_ZERO_VOLT_CHARGE_DRIVE_FET)
        begin
          drv_nxt.zero_volt_charge_drive = 1'b1;
        end
        else if (fet_cfg_i == DSCP_CFG_COMMON_FET && pms_s)
        begin
          drv_nxt.charge_gate_drive = 1'b1;
        end
      end
      DSCP_ST_RUN:
      begin
        reg_on_nxt = 1'b1;
        drv_nxt = host_drv_i;
      end
      DSCP_ST_TRIP:
      begin
        reg_on_nxt = 1'b1;
        drv_nxt = '0;
      end
      default:
      begin
        drv_nxt = '0;
      end
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      st_r <= DSCP_ST_DOWN;
      drv_o <= '0;
      regulator_on_o <= 1'b0;
    end
    else
    begin
      st_r <= st_nxt;
      drv_o <= drv_nxt;
      regulator_on_o <= reg_on_nxt;
    end
  end

  assign short_tripped_o = (st_r == DSCP_ST_TRIP);

  // -------------------------------------------------------------
  // assertions
  // -------------------------------------------------------------
  property p_trip_off;
    @(posedge clk_i) disable iff (rst_i)
      (st_r == DSCP_ST_RUN && expired && pgood_s) |=> (drv_o == '0);
  endproperty
  a_trip_off: assert property (p_trip_off) else $error("drives not off after trip");

  property p_reset_zero;
    @(posedge clk_i) $past(rst_i) |-> (cfg_r == 8'h00);
  endproperty
  a_reset_zero: assert property (p_reset_zero) else $error("register not zero after reset");

  property p_thr;
    @(posedge clk_i) disable iff (rst_i)
      (thr_code == 4'hF) |-> (thr_mv == 10'(DSCP_THR_MAX_MV));
  endproperty
  a_thr: assert property (p_thr) else $error("top threshold wrong");

  property p_disable;
    @(posedge clk_i) disable iff (rst_i)
      discharge_short_sense_disable_i |=> !expired;
  endproperty
  a_disable: assert property (p_disable) else $error("sense ran while disabled");

  property p_zero_delay;
    @(posedge clk_i) disable iff (rst_i)
      (dly_code == 4'h0 && over && !$past(over)) |-> ##1 (expired || !over);
  endproperty
  a_zero_delay: assert property (p_zero_delay) else $error("zero delay too slow");

  property p_restart;
    @(posedge clk_i) disable iff (rst_i)
      !over |=> !expired;
  endproperty
  a_restart: assert property (p_restart) else $error("expired without excess");

  property p_zv_start;
    @(posedge clk_i) disable iff (rst_i)
      (!pgood_s && fet_cfg_i == DSCP_CFG_ZERO_VOLT_CHARGE_DRIVE_FET) |=>
        (drv_o.zero_volt_charge_drive && !drv_o.charge_gate_drive);
  endproperty
  a_zv_start: assert property (p_zv_start) else $error("zero-volt start wrong");

  property p_pms;
    @(posedge clk_i) disable iff (rst_i)
      (!pgood_s && fet_cfg_i == DSCP_CFG_COMMON_FET && pms_s) |=> drv_o.charge_gate_drive;
  endproperty
  a_pms: assert property (p_pms) else $error("charge not forced on");

  property p_follow;
    @(posedge clk_i) disable iff (rst_i)
      (st_nxt == DSCP_ST_RUN) |=> (regulator_on_o && drv_o == $past(host_drv_i));
  endproperty
  a_follow: assert property (p_follow) else $error("charge not following host");

  c_trip: cover property (@(posedge clk_i) disable iff (rst_i) st_r == DSCP_ST_TRIP);
  c_power: cover property (@(posedge clk_i) disable iff (rst_i)
    st_r == DSCP_ST_DOWN ##1 st_r == DSCP_ST_RUN);
  c_blank: cover property (@(posedge clk_i) disable iff (rst_i) over ##1 !over);

endmodule : dscp_top

// File: tb/dscp_host_model.sv
`timescale 1ns/1ps
module dscp_host_model
  import dscp_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // control
  input wire logic regulator_on_i,
  input wire logic all_off_i,
  input wire logic [7:0] lag_i,
  // drives
  output dscp_pkg::dscp_drv_t host_drv_o
);
  logic [7:0] cnt_r;
  // host only wakes once the regulator feeds it; lag_i models a slow boot
  always_ff @(posedge clk_i)
  begin
    if (rst_i || !regulator_on_i)
    begin
      cnt_r <= 8'h00;
      host_drv_o <= '0;
    end
    else if (cnt_r < lag_i)
      cnt_r <= cnt_r + 8'h01;
    else
      host_drv_o <= all_off_i ? 3'h0 : 3'h6;
  end
endmodule : dscp_host_model

// File: tb/dscp_top_bench.sv
`timescale 1ns/1ps
module dscp_top_bench;
  import dscp_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic reg_wr_i = 1'b0;
  logic [7:0] reg_addr_i = 8'h00;
  logic [7:0] reg_wdata_i = 8'h00;
  logic [7:0] lag = 8'h00;
  logic sense_dis = 1'b0;
  logic precharge_mode_select = 1'b0;
  logic pgood = 1'b0;
  logic all_off = 1'b0;
  logic [DSCP_MV_W-1:0] sense = '0;
  dscp_cfg_t cfg = DSCP_CFG_ZERO_VOLT_CHARGE_DRIVE_FET;
  dscp_drv_t host_drv;
  dscp_drv_t drv_o;
  logic [7:0] reg_rdata_o;
  logic regulator_on_o;
  logic short_tripped_o;
  int errors = 0;
  int tests_run = 0;
  typedef struct {logic [12:0] e; logic [12:0] m;} dscp_note_t;
  dscp_note_t notes[$];
  always #2 clk_i = ~clk_i;

  dscp_top dut (.clk_i(clk_i), .rst_i(rst_i), .reg_wr_i(reg_wr_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
    .discharge_short_sense_disable_i(sense_dis), .host_drv_i(host_drv),
    .fet_cfg_i(cfg), .sense_mv_i(sense), .precharge_mode_select_i(precharge_mode_select),
    .supply_good_i(pgood), .drv_o(drv_o), .regulator_on_o(regulator_on_o),
    .short_tripped_o(short_tripped_o));
  dscp_host_model host (.clk_i(clk_i), .rst_i(rst_i), .regulator_on_i(regulator_on_o),
    .all_off_i(all_off), .lag_i(lag), .host_drv_o(host_drv));

  task automatic test_done();
    $display("checks %0d errors %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : test_done

  // ------------------------------------------------
  // monitor: word is {trip, regulator, drives, rdata}
  // ------------------------------------------------
  always @(negedge clk_i)
  begin
    logic [12:0] obs;
    obs = {short_tripped_o, regulator_on_o, drv_o, reg_rdata_o};
    while (notes.size() > 0)
    begin
      dscp_note_t n;
      n = notes.pop_front();
      tests_run++;
      if ((obs & n.m) !== (n.e & n.m))
      begin
        errors++;
        $display("FAIL outputs exp %h got %h", n.e & n.m, obs & n.m);
      end
    end
  end

  // notes are taken at a rising edge and checked at the falling edge after it
  task automatic note(input logic [12:0] e, input logic [12:0] m);
    notes.push_back('{e, m});
  endtask : note

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask : cyc

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_i);
    reg_addr_i <= a;
    @(posedge clk_i);
    note({5'h00, e}, 13'h00FF);
  endtask : rd

  // polls at the falling edge so the trip flag has settled
  task automatic wait_trip(input logic lvl, input int lim);
    int k;
    k = 0;
    while (short_tripped_o !== lvl && k < lim)
    begin
      @(negedge clk_i);
      k++;
    end
    if (k >= lim)
    begin
      errors++;
      $display("FAIL trip wait exp %b got %b", lvl, short_tripped_o);
      test_done();
    end
    @(posedge clk_i);
  endtask : wait_trip

  task automatic release_trip();
    sense <= '0;
    all_off <= 1'b1;
    wait_trip(1'b0, 8);
    all_off <= 1'b0;
    cyc(6);
  endtask : release_trip

  initial
  begin
    int thr;
    logic [7:0] d;
    void'($urandom(57));
    cyc(16);
    rst_i <= 1'b0;
    rd(DSCP_SCD_OFFSET, 8'h00);
    note(13'h0100, 13'h1F00);
    cfg <= DSCP_CFG_COMMON_FET;
    precharge_mode_select <= 1'b1;
    cyc(4);
    note(13'h0400, 13'h1F00);
    precharge_mode_select <= 1'b0;
    cyc(4);
    note(13'h0000, 13'h1F00);
    // precharge fet config: the mode pin must not force the charge drive
    cfg <= DSCP_CFG_PRECHG_FET;
    precharge_mode_select <= 1'b1;
    cyc(4);
    note(13'h0000, 13'h1F00);
    lag <= 8'h20;
    pgood <= 1'b1;
    cyc(6);
    note(13'h0800, 13'h1F00);
    cyc(40);
    note(13'h0E00, 13'h1F00);
    repeat (4)
    begin
      d = 8'($urandom);
      wr(DSCP_SCD_OFFSET, d);
      rd(DSCP_SCD_OFFSET, d);
      wr(8'h09, ~d);
      rd(8'h09, 8'h00);
      rd(DSCP_SCD_OFFSET, d);
    end
    // threshold sweep with no blanking
    for (int c = 0; c < 16; c++)
    begin
      thr = DSCP_THR_BASE_MV + DSCP_THR_STEP_MV * c;
      wr(DSCP_SCD_OFFSET, 8'(c));
      sense <= 10'($urandom_range(thr));
      cyc(8);
      note(13'h0E00, 13'h1F00);
      sense <= 10'(thr + 1);
      wait_trip(1'b1, 8);
      note(13'h1800, 13'h1F00);
      release_trip();
    end
    wr(DSCP_SCD_OFFSET, 8'h00);
    sense_dis <= 1'b1;
    sense <= 10'h3FF;
    cyc(10);
    note(13'h0E00, 13'h1F00);
    sense_dis <= 1'b0;
    wait_trip(1'b1, 8);
    release_trip();
    // one delay step, broken once before it runs out
    wr(DSCP_SCD_OFFSET, 8'h10);
    sense <= 10'h3FF;
    cyc(DSCP_DLY_STEP_CYC - 2000);
    sense <= '0;
    cyc(4);
    sense <= 10'h3FF;
    cyc(DSCP_DLY_STEP_CYC - 2000);
    note(13'h0E00, 13'h1F00);
    cyc(1990);
    note(13'h0E00, 13'h1F00);
    wait_trip(1'b1, 20);
    test_done();
  end
endmodule : dscp_top_bench
